// ==== logic/adc_ctrl.sv ====
/*
 * Control and output section of a 12-bit successive-approximation
 * converter: host pin decode, conversion clock, busy flag, three-state
 * result lines and an Avalon-MM register slave.
 * Assumes host pins are synchronous to clk_i and the comparator and
 * DAC sit outside this block.
 */
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module adc_ctrl (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rstn_i,
   // avalon-mm slave
   input  wire logic [adc_pkg::ADDR_W-1:0]   avs_address_i,
   input  wire logic                         avs_read_i,
   input  wire logic                         avs_write_i,
   input  wire logic [adc_pkg::DATA_W-1:0]   avs_writedata_i,
   input  wire logic [3:0]                   avs_byteenable_i,
   output      logic [adc_pkg::DATA_W-1:0]   avs_readdata_o,
   output      logic                         avs_waitrequest_o,
   // host control pins
   input  wire logic                         chip_enable_i,
   input  wire logic                         chip_select_n_i,
   input  wire logic                         read_convert_i,
   input  wire logic                         byte_select_short_cycle_i,
   input  wire logic                         word_format_i,
   // status pin
   output      logic                         conversion_busy_flag_o,
   // three-state result lines
   output      logic [adc_pkg::NIB_W-1:0]    result_high_nibble_o,
   output      logic                         result_high_nibble_oe_o,
   output      logic [adc_pkg::NIB_W-1:0]    result_mid_nibble_o,
   output      logic                         result_mid_nibble_oe_o,
   output      logic [adc_pkg::NIB_W-1:0]    result_low_nibble_o,
   output      logic                         result_low_nibble_oe_o,
   // analog side
   input  wire logic                         cmp_below_i,
   output      logic [adc_pkg::RES_W-1:0]    dac_code_o
);
   import adc_pkg::*;

   function automatic logic [NIB_W-1:0] nibble(input logic [RES_W-1:0] v,
                                               input int n);
      return v[n*NIB_W +: NIB_W];
   endfunction

   // registers
   logic [DIV_W-1:0]  div_q;
   logic [DIV_W-1:0]  div_cnt_q;
   logic [RES_W-1:0]  result_q;
   logic              conv_req_q;
   logic              short_q;
   logic              done_q;
   logic              rd_ack_q;
   logic [DATA_W-1:0] rdata_q;
   logic [NIB_W-1:0]  hi_q, mid_q, lo_q;
   logic              hi_oe_q, mid_oe_q, lo_oe_q;

   // decode wires
   logic              busy;
   logic              eoc;
   logic              tick;
   logic              active;
   logic              conv_req;
   logic              pin_start;
   logic              sw_start;
   logic              start;
   logic              start_short;
   logic              rd_en;
   logic              wr_ctrl;
   logic              hit_ctrl, hit_status, hit_result;
   logic [DATA_W-1:0] rd_mux;
   logic              hi_oe_d, mid_oe_d, lo_oe_d;
   logic [NIB_W-1:0]  mid_d;
   logic [RES_W-1:0]  sar_code;

   // host pin decode; select low is the host's part
   assign active    = chip_enable_i & ~chip_select_n_i;
   assign conv_req  = active & ~read_convert_i;
   // entering the convert state covers both a chip enable strobe and a
   // falling read/convert edge with enable held high
   assign pin_start = conv_req & ~conv_req_q;

   // bus decode
   assign hit_ctrl   = (avs_address_i == OFS_CTRL);
   assign hit_status = (avs_address_i == OFS_STATUS);
   assign hit_result = (avs_address_i == OFS_RESULT);
   assign wr_ctrl    = avs_write_i & hit_ctrl;
   assign sw_start   = wr_ctrl & avs_byteenable_i[2]
                     & avs_writedata_i[CTRL_START_BIT];

   // no abort or restart while a cycle runs
   assign start       = (pin_start | sw_start) & ~busy;
   assign start_short = pin_start ? byte_select_short_cycle_i
                                  : avs_writedata_i[CTRL_SHORT_BIT];

   // conversion clock: runs only while busy, stops at end
   // a zero divider must not wrap to the longest trial period
   assign tick = busy
               & ((div_q == '0) | (div_cnt_q >= div_q - 10'h1));

   adc_sar i_adc_sar (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .start_i     (start),
      .short_i     (start_short),
      .tick_i      (tick),
      .busy_o      (busy),
      .eoc_o       (eoc),
      .cmp_below_i (cmp_below_i),
      .code_o      (sar_code)
   );

   assign dac_code_o             = sar_code;
   assign conversion_busy_flag_o = busy;

   // read decode: nothing offered while converting the start
   // cycle is masked too, as busy rises only one edge later
   assign rd_en    = active & read_convert_i & ~busy & ~start;
   assign hi_oe_d  = rd_en & (word_format_i | ~byte_select_short_cycle_i);
   assign mid_oe_d = rd_en & (word_format_i | ~byte_select_short_cycle_i
                     | byte_select_short_cycle_i);
   assign lo_oe_d  = rd_en & byte_select_short_cycle_i;
   assign mid_d    = (~word_format_i & byte_select_short_cycle_i)
                   ? '0 : nibble(result_q, 1);

   // register read mux; unmapped offsets read zero
   assign rd_mux = hit_ctrl   ? {14'h0, short_q, 1'b0, 6'h0, div_q}
                 : hit_status ? {29'h0, done_q, short_q, busy}
                 : hit_result ? {20'h0, result_q}
                 : 32'h0;

   // one wait state on reads, writes complete at once
   assign avs_waitrequest_o = avs_read_i & ~rd_ack_q;
   assign avs_readdata_o    = rdata_q;

   // divider counter restarts at every trial bit
   always_ff @(posedge clk_i) begin
      if (!rstn_i || !busy || tick) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_q + 10'h1;
      end
   end

   // trial period setting; zero behaves as one cycle per bit
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         div_q <= DIV_RESET;
      end else if (wr_ctrl) begin
         if (avs_byteenable_i[0]) begin
            div_q[7:0] <= avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            div_q[DIV_W-1:8] <= avs_writedata_i[DIV_W-1:8];
         end
      end
   end

   // conversion bookkeeping
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         conv_req_q <= 1'b0;
         short_q    <= 1'b0;
         done_q     <= 1'b0;
         result_q   <= '0;
      end else begin
         conv_req_q <= conv_req;
         if (start) begin
            short_q <= start_short;
            done_q  <= 1'b0;
         end
         if (eoc) begin
            // final trial decision lands with the capture
            result_q                <= sar_code;
            result_q[LAST_IDX_SHT]  <= short_q ? cmp_below_i
                                              : sar_code[LAST_IDX_SHT];
            result_q[LAST_IDX_FUL]  <= short_q ? 1'b0 : cmp_below_i;
            done_q                  <= 1'b1;
         end
      end
   end

   // bus read answer
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rd_ack_q <= 1'b0;
         rdata_q  <= '0;
      end else begin
         rd_ack_q <= avs_read_i & ~rd_ack_q;
         if (avs_read_i & ~rd_ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // result lines, released unless a read is enabled
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         hi_q     <= '0;
         mid_q    <= '0;
         lo_q     <= '0;
         hi_oe_q  <= 1'b0;
         mid_oe_q <= 1'b0;
         lo_oe_q  <= 1'b0;
      end else begin
         hi_q     <= nibble(result_q, 2);
         mid_q    <= mid_d;
         lo_q     <= nibble(result_q, 0);
         hi_oe_q  <= hi_oe_d;
         mid_oe_q <= mid_oe_d;
         lo_oe_q  <= lo_oe_d;
      end
   end

   assign result_high_nibble_o    = hi_q;
   assign result_high_nibble_oe_o = hi_oe_q;
   assign result_mid_nibble_o     = mid_q;
   assign result_mid_nibble_oe_o  = mid_oe_q;
   assign result_low_nibble_o     = lo_q;
   assign result_low_nibble_oe_o  = lo_oe_q;

endmodule

// ==== logic/adc_pkg.sv ====
/*
 * Shared constants for the converter control block: result widths,
 * register offsets and fields, reset values and trial-bit timing.
 * Assumes a 200 MHz system clock and byte addressing on the bus.
 */
package adc_pkg;

   // result shape
   localparam int RES_W      = 12;
   localparam int NIB_W      = 4;
   localparam int IDX_W      = 4;
   localparam int SHORT_BITS = 8;
   localparam logic [IDX_W-1:0] MSB_IDX      = 4'hb;
   localparam logic [IDX_W-1:0] LAST_IDX_FUL = 4'h0;
   localparam logic [IDX_W-1:0] LAST_IDX_SHT = 4'(RES_W - SHORT_BITS);

   // bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h8;

   // control register fields
   localparam int DIV_W          = 10;
   localparam int CTRL_START_BIT = 16;
   localparam int CTRL_SHORT_BIT = 17;

   // status register fields
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_SHORT_BIT = 1;
   localparam int ST_DONE_BIT  = 2;

   // trial bit timing
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int TRIAL_PERIOD_NS = 1000;
   localparam int TRIAL_CYCLES    = (TRIAL_PERIOD_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(TRIAL_CYCLES);

   typedef enum logic {
      SAR_IDLE,
      SAR_TRIAL
   } adc_sar_state_e;

endpackage

// ==== logic/adc_sar.sv ====
/*
 * Successive-approximation register: walks trial bits from the top
 * down, one per conversion clock tick, and flags end of conversion.
 * Assumes the comparator input is settled when a tick arrives.
 */
`timescale 1ns/10ps
module adc_sar (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rstn_i,
   // control section
   input  wire logic                    start_i,
   input  wire logic                    short_i,
   input  wire logic                    tick_i,
   output      logic                    busy_o,
   output      logic                    eoc_o,
   // analog side
   input  wire logic                    cmp_below_i,
   output      logic [adc_pkg::RES_W-1:0] code_o
);
   import adc_pkg::*;

   adc_sar_state_e       state_q, state_d;
   logic [RES_W-1:0]     sar_q, sar_d;
   logic [IDX_W-1:0]     idx_q, idx_d;
   logic                 short_q, short_d;
   logic [IDX_W-1:0]     last_idx;
   logic                 last_trial;

   assign last_idx   = short_q ? LAST_IDX_SHT : LAST_IDX_FUL;
   assign last_trial = (idx_q == last_idx);
   assign eoc_o      = (state_q == SAR_TRIAL) && tick_i && last_trial;
   assign busy_o     = (state_q == SAR_TRIAL);
   assign code_o     = sar_q;

   always_comb begin
      state_d = state_q;
      sar_d   = sar_q;
      idx_d   = idx_q;
      short_d = short_q;
      unique case (state_q)
         SAR_IDLE: begin
            if (start_i) begin
               // whole register cleared, then top trial bit raised
               sar_d          = '0;
               sar_d[MSB_IDX] = 1'b1;
               idx_d          = MSB_IDX;
               short_d        = short_i;
               state_d        = SAR_TRIAL;
            end
         end
         SAR_TRIAL: begin
            if (tick_i) begin
               sar_d[idx_q] = cmp_below_i;
               if (last_trial) begin
                  // low bits of a short cycle were never raised
                  state_d = SAR_IDLE;
               end else begin
                  idx_d        = idx_q - 4'h1;
                  sar_d[idx_d] = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         state_q <= SAR_IDLE;
         sar_q   <= '0;
         idx_q   <= '0;
         short_q <= 1'b0;
      end else begin
         state_q <= state_d;
         sar_q   <= sar_d;
         idx_q   <= idx_d;
         short_q <= short_d;
      end
   end

endmodule

// ==== logic/adc_ctrl_fix_note.sv ====
/*
 * Holds no logic: the converter control lives in adc_ctrl.sv and the
 * approximation register in adc_sar.sv.
 * Assumes nothing of its surroundings.
 */

// ==== bench/adc_cmp_model.sv ====
/* comparator stand-in for the converter's analog side.
   assumes the bench sets the input level as a code. */
`timescale 1ns/10ps
module adc_cmp_model (
   // from the block
   input  wire logic [11:0] dac_code_i,
   // level under test
   input  wire logic [11:0] level_i,
   // to the block
   output      logic        cmp_below_o
);
   // input sits half a step above its code, so equal counts as below
   assign cmp_below_o = (dac_code_i <= level_i);
endmodule

// ==== bench/adc_ctrl_checker.sv ====
/* assertions on the host pins and result lines of adc_ctrl.
   assumes it is bound to adc_ctrl and sees its ports only. */
`timescale 1ns/10ps
module adc_ctrl_checker (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rstn_i,
   // host pins
   input wire logic        chip_enable_i,
   input wire logic        chip_select_n_i,
   input wire logic        read_convert_i,
   input wire logic        byte_select_short_cycle_i,
   input wire logic        word_format_i,
   // outputs
   input wire logic        conversion_busy_flag_o,
   input wire logic        result_high_nibble_oe_o,
   input wire logic        result_mid_nibble_oe_o,
   input wire logic [3:0]  result_mid_nibble_o,
   input wire logic        result_low_nibble_oe_o,
   input wire logic [11:0] dac_code_o
);
   wire any_oe = result_high_nibble_oe_o | result_mid_nibble_oe_o
                 | result_low_nibble_oe_o;
   wire conv_pins = chip_enable_i & ~chip_select_n_i & ~read_convert_i;
   wire byte_low = ~word_format_i & byte_select_short_cycle_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   chk_low_released: assert property (
      !byte_select_short_cycle_i |=> !result_low_nibble_oe_o)
      else $error("low nibble driven without byte select");
   chk_busy_holds: assert property (
      $rose(conversion_busy_flag_o) |-> conversion_busy_flag_o[*8])
      else $error("busy dropped too early");
   chk_busy_no_data: assert property (
      conversion_busy_flag_o |-> !any_oe)
      else $error("result offered during conversion");
   chk_start_clears: assert property (
      $rose(conversion_busy_flag_o) |-> dac_code_o == 12'h800)
      else $error("first trial code wrong");
   chk_start_taken: assert property (
      $rose(conv_pins) && !conversion_busy_flag_o
      |=> conversion_busy_flag_o)
      else $error("convert request not taken");
   chk_unselected_quiet: assert property (
      (chip_select_n_i || !chip_enable_i) |=> !any_oe)
      else $error("lines driven while not addressed");
   chk_mid_zero: assert property (
      result_mid_nibble_oe_o && $past(byte_low)
      |-> result_mid_nibble_o == 4'h0)
      else $error("middle nibble not zero");
   chk_byte_hi_off: assert property (
      $past(byte_low) |-> !result_high_nibble_oe_o)
      else $error("high nibble driven in low byte");
   chk_word_read: assert property (
      $past(chip_enable_i && !chip_select_n_i && read_convert_i
            && word_format_i && !conversion_busy_flag_o)
      |-> conversion_busy_flag_o
          || (result_high_nibble_oe_o && result_mid_nibble_oe_o))
      else $error("word read not enabled");
endmodule

bind adc_ctrl adc_ctrl_checker i_adc_ctrl_checker (.*);

// ==== bench/sar_adc_control_and_output_bench.sv ====
/* self-checking bench for adc_ctrl: register access over Avalon-MM,
   conversions and reads through the host pins.
   assumes adc_pkg, adc_ctrl and the comparator model are compiled. */
`timescale 1ns/10ps
module sar_adc_control_and_output_bench;
   import adc_pkg::*;
   logic              clk_i = 1'b0;
   logic              rstn_i = 1'b0;
   logic [ADDR_W-1:0] adr = '0;
   logic              rd = 1'b0;
   logic              wr = 1'b0;
   logic [DATA_W-1:0] wdat = '0;
   logic [DATA_W-1:0] rdat;
   logic [DATA_W-1:0] v;
   logic              wreq;
   logic              ce = 1'b0;
   logic              cs_n = 1'b1;
   logic              rc = 1'b1;
   logic              a0 = 1'b0;
   logic              wf = 1'b1;
   logic              busy, below, hi_oe, mid_oe, lo_oe;
   logic [3:0]        hi, mid, lo;
   logic [RES_W-1:0]  dac;
   logic [RES_W-1:0]  level = '0;
   int                n_fail = 0;
   int                n_compared = 0;

   adc_ctrl i_adc_ctrl (
      .clk_i(clk_i), .rstn_i(rstn_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .chip_enable_i(ce), .chip_select_n_i(cs_n),
      .read_convert_i(rc), .byte_select_short_cycle_i(a0),
      .word_format_i(wf), .conversion_busy_flag_o(busy),
      .result_high_nibble_o(hi), .result_high_nibble_oe_o(hi_oe),
      .result_mid_nibble_o(mid), .result_mid_nibble_oe_o(mid_oe),
      .result_low_nibble_o(lo), .result_low_nibble_oe_o(lo_oe),
      .cmp_below_i(below), .dac_code_o(dac));
   adc_cmp_model i_adc_cmp_model (
      .dac_code_i(dac), .level_i(level), .cmp_below_o(below));

   always #2.5 clk_i = ~clk_i;

   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // no fixed latency assumed: holds until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      // waitrequest is seen at the rising edge, before that edge updates
      do begin
         @(posedge clk_i);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic pins(input logic c, s, r, b, f);
      @(posedge clk_i);
      ce <= c;
      cs_n <= s;
      rc <= r;
      a0 <= b;
      wf <= f;
   endtask

   // mid-run it attempts a read, then a restart; both must be ignored
   task automatic conv(input logic b, input logic [11:0] lvl, input int nx);
      int n;
      pins(1'b1, 1'b0, 1'b0, b, 1'b1);
      level <= lvl;
      @(posedge clk_i);
      #1;
      check(32'(busy), 32'h1, "busy at start");
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         n++;
         @(posedge clk_i);
         if (n == 3)
            rc <= 1'b1;
         if (n == 6)
            rc <= 1'b0;
         #1;
         if (n == 5)
            check(32'({hi_oe, mid_oe, lo_oe}), 32'h0, "oe busy");
      end
      check(32'(n), 32'(nx), "busy cycles");
      pins(1'b1, 1'b0, 1'b1, b, 1'b1);
   endtask

   task automatic look(input logic f, b, input logic [2:0] oex,
                       input logic [11:0] dx);
      pins(1'b1, 1'b0, 1'b1, b, f);
      repeat (2) @(posedge clk_i);
      #1;
      check(32'({hi_oe, mid_oe, lo_oe}), 32'(oex), "enables");
      check(32'({hi, mid, lo} & {{4{oex[2]}}, {4{oex[1]}}, {4{oex[0]}}}),
            32'(dx), "result lines");
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      #1;
      check(32'({busy, hi_oe, mid_oe, lo_oe}), 32'h0, "idle");
      bus(1'b1, OFS_CTRL, 32'h2, v);
      bus(1'b0, 4'hc, 32'h0, v);
      check(v, 32'h0, "unmapped read");
      conv(1'b0, 12'ha5c, 24);
      look(1'b1, 1'b0, 3'b110, 12'ha50);
      look(1'b1, 1'b1, 3'b111, 12'ha5c);
      look(1'b0, 1'b0, 3'b110, 12'ha50);
      look(1'b0, 1'b1, 3'b011, 12'h00c);
      bus(1'b0, OFS_RESULT, 32'h0, v);
      check(v, 32'ha5c, "result register");
      bus(1'b0, OFS_STATUS, 32'h0, v);
      check(v, 32'h4, "status");
      conv(1'b1, 12'h3b7, 16);
      look(1'b1, 1'b1, 3'b111, 12'h3b0);
      // register start, short cycle, while the pins ask for a read
      @(posedge clk_i);
      level <= 12'h6e1;
      bus(1'b1, OFS_CTRL, 32'h30002, v);
      bus(1'b0, OFS_STATUS, 32'h0, v);
      check(v, 32'h3, "status running");
      bus(1'b0, OFS_CTRL, 32'h0, v);
      check(v, 32'h20002, "control");
      while (busy === 1'b1)
         @(posedge clk_i);
      bus(1'b0, OFS_RESULT, 32'h0, v);
      check(v, 32'h6e0, "short result");
      bus(1'b0, OFS_STATUS, 32'h0, v);
      check(v, 32'h6, "status after short");
      pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      @(posedge clk_i);
      #1;
      check(32'(busy), 32'h0, "unaddressed start");
      give_verdict;
   end

   // the whole run needs well under 400 cycles
   initial begin
      #10000;
      n_fail++;
      give_verdict;
   end
endmodule
